// ===== bench/rrpc_ctrl_monitor.sv
// Purpose: Port checker of the retry and polling controller
// Assumes: Sees the ports of rrpc_ctrl only
// Notes: Bound to the design at the foot of this file
`timescale 1ns/10ps
module rrpc_ctrl_monitor (
   input wire logic CLK,
   input wire logic RST,
   input wire logic CMD_VALID,
   input wire logic RSP_VALID,
   input wire logic RSP_ERR,
   input wire logic [15:0] RSP_DATA,
   input wire logic HOST_PKT_VALID,
   input wire logic HOST_PKT_TAKE,
   input wire logic HOST_PKT_ACKED,
   input wire logic RADIO_TX_REQ,
   input wire rrpc_pkg::rrpc_tx_t RADIO_TX,
   input wire logic RX_PKT_VALID,
   input wire logic HOST_DELIVER,
   input wire logic RX_DUP_DROP,
   input wire logic LED_TX
);
   import rrpc_pkg::*;
   // One clock domain, reset stops every attempt
   default clocking @(posedge CLK); endclocking
   default disable iff (RST);
   property p_rsp; RSP_VALID == $past(CMD_VALID); endproperty
   a_rsp: assert property (p_rsp) else $error("answer not one cycle after command");
   property p_err; RSP_ERR |-> RSP_VALID && RSP_DATA == 16'h0000; endproperty
   a_err: assert property (p_err) else $error("refusal without valid or zero data");
   property p_init; RADIO_TX_REQ |-> RADIO_TX.init ##1 !RADIO_TX_REQ; endproperty
   a_init: assert property (p_init) else $error("copy without initializer");
   property p_rx; RX_PKT_VALID |=> HOST_DELIVER != RX_DUP_DROP; endproperty
   a_rx: assert property (p_rx) else $error("packet not delivered or dropped once");
   property p_rxq; !RX_PKT_VALID |=> !HOST_DELIVER && !RX_DUP_DROP; endproperty
   a_rxq: assert property (p_rxq) else $error("delivery without a packet");
   property p_led; RADIO_TX_REQ && RADIO_TX.poll |-> !LED_TX ##1 !LED_TX; endproperty
   a_led: assert property (p_led) else $error("poll shown on transmit lamp");
   property p_ack; HOST_PKT_ACKED |-> HOST_PKT_TAKE ##1 !HOST_PKT_TAKE; endproperty
   a_ack: assert property (p_ack) else $error("acknowledge flag without take");
   property p_take; HOST_PKT_TAKE |-> $past(HOST_PKT_VALID); endproperty
   a_take: assert property (p_take) else $error("take without host packet");
endmodule // rrpc_ctrl_monitor
bind rrpc_ctrl rrpc_ctrl_monitor i_rrpc_ctrl_monitor (.*);

// ===== bench/rrpc_radio_model.sv
// Purpose: Peer radio on the far side of the radio port
// Assumes: One request at a time
// Notes: Ends each send after DELAY cycles, acknowledges data when ack_on
`timescale 1ns/10ps
module rrpc_radio_model #(
   parameter int DELAY = 3
) (
   input wire logic clk,
   input wire logic rst,
   input wire logic tx_req,
   input wire rrpc_pkg::rrpc_tx_t tx,
   input wire logic ack_on,
   output logic tx_done,
   output logic ack_valid,
   output rrpc_pkg::rrpc_id_t ack_id
);
   import rrpc_pkg::*;
   int cnt = 0; // Cycles of air time left
   logic ack_pend = 1'h0; // Acknowledge due next cycle
   always @(posedge clk) begin
      tx_done <= 1'h0;
      ack_valid <= ack_pend;
      ack_id <= ack_pend ? tx.id : ~tx.id;
      ack_pend <= 1'h0;
      if (rst)
         cnt <= 0;
      else if (tx_req)
         cnt <= DELAY;
      else if (cnt > 0) begin
         cnt <= cnt - 1;
         tx_done <= (cnt == 1);
         ack_pend <= (cnt == 1) && ack_on && !tx.poll;
      end
   end
endmodule // rrpc_radio_model

// ===== bench/tb_rrpc_ctrl.sv
// Purpose: Self-checking bench of the retry and polling controller
// Assumes: Millisecond shortened to 10 cycles
// Notes: Command, packet and receive tasks drive the host side; the radio model drives the radio port
`timescale 1ns/10ps
`include "rrpc_map.svh"
module tb_rrpc_ctrl;
   import rrpc_pkg::*;
   logic CLK, RST, CMD_VALID, CMD_WRITE, RSP_VALID, RSP_ERR, ack_on, ak;
   logic [7:0] CMD_CODE;
   logic [15:0] CMD_WDATA, RSP_DATA;
   logic HOST_PKT_VALID, HOST_PKT_TAKE, HOST_PKT_ACKED, RADIO_TX_REQ, RADIO_TX_DONE;
   logic RADIO_ACK_VALID, RX_PKT_VALID, RX_POLL_VALID, HOST_DELIVER, RX_DUP_DROP;
   logic LED_TX, LED_RX;
   rrpc_tx_t RADIO_TX;
   rrpc_id_t RADIO_ACK_ID, RX_PKT_ID;
   int errors, checked, n_req, b;
   logic [15:0] dst [0:63]; // Destination of each request
   rrpc_ctrl #(.MS_CYCLES(10)) i_rrpc_ctrl (.*);
   rrpc_radio_model #(.DELAY(3)) i_rrpc_radio_model (.clk(CLK), .rst(RST),
      .tx_req(RADIO_TX_REQ), .tx(RADIO_TX), .ack_on(ack_on), .tx_done(RADIO_TX_DONE),
      .ack_valid(RADIO_ACK_VALID), .ack_id(RADIO_ACK_ID));
   initial begin
      CLK = 1'h0;
      forever #50 CLK = ~CLK;
   end
   // Log every radio request
   always @(posedge CLK) begin
      if (RADIO_TX_REQ) begin
         dst[n_req[5:0]] <= RADIO_TX.dest;
         n_req <= n_req + 1;
      end
   end
   task automatic check(input logic [15:0] s, input logic [15:0] e);
      checked++;
      if (s !== e) begin
         errors++;
         $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, s, e);
      end
   endtask
   // One command, answer checked one cycle later
   task automatic cmd(input logic w, input logic [7:0] c, input logic [15:0] d,
      input logic [15:0] ed, input logic ee);
      @(posedge CLK);
      CMD_VALID <= 1'h1;
      CMD_WRITE <= w;
      CMD_CODE <= c;
      CMD_WDATA <= d;
      @(posedge CLK);
      CMD_VALID <= 1'h0;
      #1;
      check(RSP_DATA, ed);
      check({14'h0000, RSP_VALID, RSP_ERR}, {14'h0000, 1'h1, ee});
   endtask
   // One host packet held until taken; pf holds it 20 cycles, checks no request, then gives a poll
   task automatic send(input logic pf, input logic [15:0] en, input logic ea);
      b = n_req;
      @(posedge CLK);
      HOST_PKT_VALID <= 1'h1;
      if (pf) begin
         repeat (20) @(posedge CLK);
         check(16'(n_req - b), 16'h0000);
         RX_POLL_VALID <= 1'h1;
         @(posedge CLK);
         RX_POLL_VALID <= 1'h0;
      end
      for (int i = 0; i < 4000 && HOST_PKT_TAKE !== 1'h1; i++) @(posedge CLK);
      HOST_PKT_VALID <= 1'h0;
      check({HOST_PKT_TAKE, HOST_PKT_ACKED, 14'(n_req - b)}, {1'h1, ea, en[13:0]});
   endtask
   task automatic rx(input logic [23:0] id, input logic dl);
      @(posedge CLK);
      RX_PKT_VALID <= 1'h1;
      RX_PKT_ID <= id;
      @(posedge CLK);
      RX_PKT_VALID <= 1'h0;
      #1;
      check({13'h0000, LED_RX, HOST_DELIVER, RX_DUP_DROP}, {13'h0000, 1'h1, dl, !dl});
   endtask
   task automatic tally_and_finish;
      $display("comparisons %0d mismatches %0d", checked, errors);
      if (errors == 0 && checked > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask
   initial begin
      repeat (60000) @(posedge CLK);
      errors++;
      tally_and_finish;
   end
   initial begin
      {RST, CMD_VALID, CMD_WRITE, CMD_CODE, CMD_WDATA} = {2'h2, 25'h0000000};
      {HOST_PKT_VALID, RX_PKT_VALID, RX_PKT_ID, RX_POLL_VALID, ack_on} = 28'h0000000;
      {errors, checked, n_req} = {32'h0, 32'h0, 32'h0};
      repeat (3) @(posedge CLK);
      RST <= 1'h0;
      cmd(1'h0, `RRPC_OFS_RETRY_LIMIT, 16'h0000, 16'h000A, 1'h0);
      cmd(1'h0, `RRPC_OFS_RAND_SLOTS, 16'h0000, 16'h0000, 1'h0);
      cmd(1'h0, `RRPC_OFS_REPEAT_COUNT, 16'h0000, 16'h0000, 1'h0);
      cmd(1'h0, 8'h7F, 16'h0000, 16'h0000, 1'h1);
      cmd(1'h1, `RRPC_OFS_RADIO_ROLE, 16'h0007, 16'h0000, 1'h1);
      $display("test registers done");
      cmd(1'h1, `RRPC_OFS_REPEAT_COUNT, 16'h0002, 16'h0000, 1'h0);
      send(1'h0, 16'h0003, 1'h0);
      cmd(1'h1, `RRPC_OFS_REPEAT_COUNT, 16'h0000, 16'h0002, 1'h0);
      cmd(1'h1, `RRPC_OFS_RETRY_LIMIT, 16'h0001, 16'h000A, 1'h0);
      cmd(1'h1, `RRPC_OFS_DEST_ADDR, 16'h0005, 16'h0000, 1'h0);
      send(1'h0, 16'h0002, 1'h0);
      cmd(1'h1, `RRPC_OFS_MISSED_ACK, 16'hFFFF, 16'h0002, 1'h0);
      cmd(1'h1, `RRPC_OFS_RAND_SLOTS, 16'h0001, 16'h0000, 1'h0);
      send(1'h0, 16'h0002, 1'h0);
      cmd(1'h0, `RRPC_OFS_MISSED_ACK, 16'h0000, 16'hFFFF, 1'h0);
      ack_on <= 1'h1;
      send(1'h0, 16'h0001, 1'h1);
      ack_on <= 1'h0;
      cmd(1'h1, `RRPC_OFS_DEST_ADDR, `RRPC_BCAST_ADDR, 16'h0005, 1'h0);
      send(1'h0, 16'h0001, 1'h0);
      cmd(1'h1, `RRPC_OFS_DEST_ADDR, 16'h0005, 16'hFFFF, 1'h0);
      cmd(1'h1, `RRPC_OFS_RADIO_ROLE, 16'h0005, 16'h0000, 1'h0);
      send(1'h0, 16'h0001, 1'h0);
      $display("test transmit done");
      rx(24'h000701, 1'h1);
      rx(24'h000701, 1'h0);
      rx(24'h000702, 1'h1);
      $display("test receive done");
      cmd(1'h1, `RRPC_OFS_RETRY_LIMIT, 16'h0000, 16'h0001, 1'h0);
      cmd(1'h1, `RRPC_OFS_RADIO_ROLE, 16'h0004, 16'h0005, 1'h0);
      send(1'h1, 16'h0001, 1'h0);
      cmd(1'h1, `RRPC_OFS_FIRST_POLLED, 16'h0002, 16'h0000, 1'h0);
      cmd(1'h1, `RRPC_OFS_POLL_INTERVAL, 16'h0001, 16'h0040, 1'h0);
      b = n_req;
      cmd(1'h1, `RRPC_OFS_RADIO_ROLE, 16'h0003, 16'h0004, 1'h0);
      for (int i = 0; i < 3000 && n_req < b + 6; i++) @(posedge CLK);
      check(dst[6'(b + 4)], 16'h0002);
      check(dst[6'(b + 5)], 16'h0003);
      $display("test polling done");
      tally_and_finish;
   end
endmodule // tb_rrpc_ctrl

// ===== src/rrpc_ctrl.sv
// Purpose: Repeat, acknowledge-retry and polling control of a packet radio modem
// Assumes: Address filter and framer sit outside; all inputs are on CLK
// Notes: Settings are reached by command code over the command port
`timescale 1ns/10ps
`include "rrpc_map.svh"

module rrpc_ctrl #(
   parameter int MS_CYCLES = `RRPC_MS_CYCLES,
   parameter int DUP_DEPTH = 4
) (
   input wire logic CLK,
   input wire logic RST,
   input wire logic CMD_VALID,
   input wire logic CMD_WRITE,
   input wire logic [7:0] CMD_CODE,
   input wire logic [15:0] CMD_WDATA,
   output logic RSP_VALID,
   output logic RSP_ERR,
   output logic [15:0] RSP_DATA,
   input wire logic HOST_PKT_VALID,
   output logic HOST_PKT_TAKE,
   output logic HOST_PKT_ACKED,
   output logic RADIO_TX_REQ,
   output rrpc_pkg::rrpc_tx_t RADIO_TX,
   input wire logic RADIO_TX_DONE,
   input wire logic RADIO_ACK_VALID,
   input wire rrpc_pkg::rrpc_id_t RADIO_ACK_ID,
   input wire logic RX_PKT_VALID,
   input wire rrpc_pkg::rrpc_id_t RX_PKT_ID,
   input wire logic RX_POLL_VALID,
   output logic HOST_DELIVER,
   output logic RX_DUP_DROP,
   output logic LED_TX,
   output logic LED_RX
);
   import rrpc_pkg::*;

   // ----------------------------------------
   // Parameter checks
   // ----------------------------------------
   if (MS_CYCLES < 2 || DUP_DEPTH < 1 || DUP_DEPTH > 256) begin : g_bad_param
      $error("rrpc_ctrl: MS_CYCLES or DUP_DEPTH out of range");
   end

   localparam int MSW = $clog2(MS_CYCLES);
   localparam int DPW = (DUP_DEPTH > 1) ? $clog2(DUP_DEPTH) : 1;

   // ----------------------------------------
   // Settings and command port
   // ----------------------------------------
   logic [15:0] dest_q, dest_d; // destination_address
   logic [15:0] mask_q, mask_d; // address_mask, kept for the filter
   logic [7:0] retry_q, retry_d; // ack_retry_limit
   logic [7:0] slots_q, slots_d; // random_delay_slots
   logic [15:0] missed_q, missed_d; // missed_ack_count
   logic [15:0] own_q, own_d; // own_address
   logic [2:0] role_q, role_d; // radio_role
   logic [7:0] repeat_q, repeat_d; // repeat_transmit_count
   logic [15:0] pint_q, pint_d; // poll_interval
   logic [15:0] pfirst_q, pfirst_d; // first_polled_address
   logic [15:0] plast_q, plast_d; // last_polled_address
   logic rsp_valid_q, rsp_valid_d; // Answer strobe
   logic rsp_err_q, rsp_err_d; // Unknown code or refused role value
   logic [15:0] rsp_data_q, rsp_data_d; // Read data
   logic miss_evt; // Acknowledgement wait expired

   // Decode reads, writes and the missed count update
   always_comb begin
      dest_d = dest_q;
      mask_d = mask_q;
      retry_d = retry_q;
      slots_d = slots_q;
      missed_d = missed_q;
      own_d = own_q;
      role_d = role_q;
      repeat_d = repeat_q;
      pint_d = pint_q;
      pfirst_d = pfirst_q;
      plast_d = plast_q;
      rsp_valid_d = CMD_VALID;
      rsp_err_d = 1'b0;
      rsp_data_d = 16'h0000;
      if (CMD_VALID) begin
         case (CMD_CODE)
            `RRPC_OFS_DEST_ADDR: begin
               rsp_data_d = dest_q;
               if (CMD_WRITE) dest_d = CMD_WDATA;
            end
            `RRPC_OFS_ADDR_MASK: begin
               rsp_data_d = mask_q;
               if (CMD_WRITE) mask_d = CMD_WDATA;
            end
            `RRPC_OFS_RETRY_LIMIT: begin
               rsp_data_d = {8'h00, retry_q};
               if (CMD_WRITE) retry_d = CMD_WDATA[7:0];
            end
            `RRPC_OFS_RAND_SLOTS: begin
               rsp_data_d = {8'h00, slots_q};
               if (CMD_WRITE) slots_d = CMD_WDATA[7:0];
            end
            `RRPC_OFS_MISSED_ACK: begin
               rsp_data_d = missed_q;
               if (CMD_WRITE) missed_d = CMD_WDATA;
            end
            `RRPC_OFS_OWN_ADDR: begin
               rsp_data_d = own_q;
               if (CMD_WRITE) own_d = CMD_WDATA;
            end
            `RRPC_OFS_RADIO_ROLE: begin
               rsp_data_d = {13'h0000, role_q};
               if (CMD_WRITE) begin
                  case (CMD_WDATA)
                     16'h0000, 16'h0003, 16'h0004, 16'h0005, 16'h0006: role_d = CMD_WDATA[2:0];
                     // Refused value answers with zero data
                     default: begin
                        rsp_err_d = 1'b1;
                        rsp_data_d = 16'h0000;
                     end
                  endcase
               end
            end
            `RRPC_OFS_REPEAT_COUNT: begin
               rsp_data_d = {8'h00, repeat_q};
               if (CMD_WRITE) repeat_d = CMD_WDATA[7:0];
            end
            `RRPC_OFS_POLL_INTERVAL: begin
               rsp_data_d = pint_q;
               if (CMD_WRITE) pint_d = CMD_WDATA;
            end
            `RRPC_OFS_FIRST_POLLED: begin
               rsp_data_d = pfirst_q;
               if (CMD_WRITE) pfirst_d = CMD_WDATA;
            end
            `RRPC_OFS_LAST_POLLED: begin
               rsp_data_d = plast_q;
               if (CMD_WRITE) plast_d = CMD_WDATA;
            end
            default: rsp_err_d = 1'b1;
         endcase
      end
      // count misses, saturate; the event wins over a host write
      if (miss_evt) begin
         missed_d = (missed_q == 16'hFFFF) ? missed_q : missed_q + 16'h0001;
      end
   end

   // Register settings
   always_ff @(posedge CLK) begin
      if (RST) begin
         dest_q <= `RRPC_RST_DEST_ADDR;
         mask_q <= `RRPC_RST_ADDR_MASK;
         retry_q <= `RRPC_RST_RETRY_LIMIT;
         slots_q <= `RRPC_RST_RAND_SLOTS;
         missed_q <= `RRPC_RST_MISSED_ACK;
         own_q <= `RRPC_RST_OWN_ADDR;
         role_q <= `RRPC_RST_RADIO_ROLE;
         repeat_q <= `RRPC_RST_REPEAT_COUNT;
         pint_q <= `RRPC_RST_POLL_INTERVAL;
         pfirst_q <= `RRPC_RST_FIRST_POLLED;
         plast_q <= `RRPC_RST_LAST_POLLED;
         rsp_valid_q <= 1'b0;
         rsp_err_q <= 1'b0;
         rsp_data_q <= 16'h0000;
      end else begin
         dest_q <= dest_d;
         mask_q <= mask_d;
         retry_q <= retry_d;
         slots_q <= slots_d;
         missed_q <= missed_d;
         own_q <= own_d;
         role_q <= role_d;
         repeat_q <= repeat_d;
         pint_q <= pint_d;
         pfirst_q <= pfirst_d;
         plast_q <= plast_d;
         rsp_valid_q <= rsp_valid_d;
         rsp_err_q <= rsp_err_d;
         rsp_data_q <= rsp_data_d;
      end
   end

   // ----------------------------------------
   // Receive side: duplicate filter
   // ----------------------------------------
   rrpc_id_t dup_id_q [DUP_DEPTH]; // Identifiers seen
   logic [DUP_DEPTH-1:0] dup_vld_q; // Entry valid
   logic [DUP_DEPTH-1:0] dup_hit; // Match per entry
   logic [DPW-1:0] dup_ptr_q, dup_ptr_d; // Replace pointer
   logic deliver_d, drop_d; // Receive outcome

   for (genvar i = 0; i < DUP_DEPTH; i++) begin : g_dup
      assign dup_hit[i] = dup_vld_q[i] && (dup_id_q[i] == RX_PKT_ID);
      always_ff @(posedge CLK) begin
         if (RST) begin
            dup_vld_q[i] <= 1'b0;
            dup_id_q[i] <= '0;
         end else if (deliver_d && dup_ptr_q == DPW'(i)) begin
            dup_vld_q[i] <= 1'b1;
            dup_id_q[i] <= RX_PKT_ID;
         end
      end
   end

   always_comb begin
      deliver_d = RX_PKT_VALID && (dup_hit == '0);
      drop_d = RX_PKT_VALID && (dup_hit != '0);
      dup_ptr_d = dup_ptr_q;
      if (deliver_d) begin
         dup_ptr_d = (dup_ptr_q == DPW'(DUP_DEPTH - 1)) ? '0 : dup_ptr_q + 1'b1;
      end
   end

   // ----------------------------------------
   // Millisecond tick and random source
   // ----------------------------------------
   logic [MSW-1:0] ms_cnt_q, ms_cnt_d; // Prescaler
   logic ms_tick; // One cycle per millisecond
   logic [7:0] rnd; // Random byte

   always_comb begin
      ms_tick = (ms_cnt_q == MSW'(MS_CYCLES - 1));
      ms_cnt_d = ms_tick ? '0 : ms_cnt_q + 1'b1;
   end

   rrpc_lfsr u_lfsr (
      .CLK(CLK),
      .RST(RST),
      .RAND(rnd)
   );

   // ----------------------------------------
   // Transmit sequencer
   // ----------------------------------------
   rrpc_state_t st_q, st_d; // Sequencer state
   logic [7:0] copies_q, copies_d; // Copies still to send
   logic [8:0] tries_q, tries_d; // Sends made under acknowledgement
   logic ackm_q, ackm_d; // Acknowledgement mode latched
   logic [7:0] seq_q, seq_d; // Running number
   logic [15:0] tmr_q, tmr_d; // Millisecond timer of the sequence
   logic [15:0] ptmr_q, ptmr_d; // Poll gap timer
   logic [15:0] paddr_q, paddr_d; // Next remote to poll
   logic polled_q, polled_d; // Remote has been polled
   logic [19:0] hold_q, hold_d; // Remote hold time left
   logic hrun_q, hrun_d; // Hold timer running
   logic req_q, req_d; // Radio request strobe
   rrpc_tx_t tx_q, tx_d; // Radio request fields
   logic take_q, take_d, acked_q, acked_d; // Host packet finished
   logic ledtx_q, ledtx_d, ledrx_q, ledrx_d; // Indicators
   logic ack_ok; // Acknowledgement allowed for a new packet
   logic ack_match; // Acknowledgement for current packet

   always_comb begin
      ack_ok = (repeat_q == 8'h00) && (retry_q != 8'h00) && (dest_q != `RRPC_BCAST_ADDR)
         && (role_q != ROLE_REPEATER) && (role_q != ROLE_REPEATER_END);
      ack_match = RADIO_ACK_VALID && (RADIO_ACK_ID == tx_q.id);
      st_d = st_q;
      copies_d = copies_q;
      tries_d = tries_q;
      ackm_d = ackm_q;
      seq_d = seq_q;
      tmr_d = (ms_tick && tmr_q != 16'h0000) ? tmr_q - 16'h0001 : tmr_q;
      ptmr_d = (ms_tick && ptmr_q != 16'h0000) ? ptmr_q - 16'h0001 : ptmr_q;
      paddr_d = paddr_q;
      // remember a poll; the poll wins over its own clear
      polled_d = polled_q || RX_POLL_VALID;
      hold_d = (ms_tick && hold_q != 20'h00000) ? hold_q - 20'h00001 : hold_q;
      hrun_d = hrun_q;
      req_d = 1'b0;
      tx_d = tx_q;
      take_d = 1'b0;
      acked_d = 1'b0;
      miss_evt = 1'b0;
      ledtx_d = (st_q == ST_SEND);
      // receive and poll traffic on the receive indicator
      ledrx_d = RX_PKT_VALID || RX_POLL_VALID || (st_q == ST_POLL);
      // remote starts the hold time when data appears
      if (role_q == ROLE_POLL_REMOTE && HOST_PKT_VALID && !take_q && !hrun_q) begin
         hrun_d = 1'b1;
         hold_d = 20'(pint_q * `RRPC_REMOTE_HOLD_SCALE) + 20'h00001;
      end
      case (st_q)
         ST_IDLE: begin
            // Host drops valid in the take cycle, so it is ignored then
            if (HOST_PKT_VALID && !take_q && (role_q != ROLE_POLL_REMOTE || polled_q)) begin
               // every role but remote sends at once, remote after poll
               polled_d = RX_POLL_VALID;
               hrun_d = 1'b0;
               // extra copies equal the repeat count
               copies_d = repeat_q;
               ackm_d = ack_ok;
               tries_d = 9'h001;
               seq_d = seq_q + 8'h01;
               tx_d = '{init: 1'b1, poll: 1'b0, dest: dest_q,
                        id: '{src: own_q, seq: seq_q + 8'h01}};
               req_d = 1'b1;
               st_d = ST_SEND;
            end else if (role_q == ROLE_POLL_REMOTE && hrun_q && hold_q == 20'h00000) begin
               hrun_d = 1'b0;
               take_d = 1'b1;
            end else if (role_q == ROLE_POLL_BASE && ptmr_q == 16'h0000
                         && pfirst_q <= plast_q) begin
               // poll next remote of the range
               tx_d = '{init: 1'b1, poll: 1'b1, dest: paddr_q,
                        id: '{src: own_q, seq: seq_q}};
               req_d = 1'b1;
               st_d = ST_POLL;
            end else if (role_q == ROLE_POLL_REMOTE && polled_q && !HOST_PKT_VALID) begin
               // Poll with nothing to send is used up
               polled_d = RX_POLL_VALID;
            end
         end
         ST_SEND: begin
            if (RADIO_TX_DONE) begin
               if (ackm_q) begin
                  tmr_d = `RRPC_ACK_WAIT_MS + 16'h0001;
                  st_d = ST_ACK_WAIT;
               end else if (copies_q != 8'h00) begin
                  // next copy back to back, own initializer
                  copies_d = copies_q - 8'h01;
                  req_d = 1'b1;
               end else begin
                  take_d = 1'b1;
                  st_d = ST_IDLE;
               end
            end
         end
         ST_ACK_WAIT: begin
            if (ack_match) begin
               take_d = 1'b1;
               acked_d = 1'b1;
               st_d = ST_IDLE;
            end else if (tmr_q == 16'h0000) begin
               miss_evt = 1'b1;
               // at most limit plus one sends
               if (tries_q >= {1'b0, retry_q} + 9'h001) begin
                  take_d = 1'b1;
                  st_d = ST_IDLE;
               end else if (slots_q != 8'h00) begin
                  // random number of slots before retry
                  tmr_d = 16'(({8'h00, rnd % slots_q} + 16'h0001) * `RRPC_SLOT_MS) + 16'h0001;
                  st_d = ST_BACKOFF;
               end else begin
                  tries_d = tries_q + 9'h001;
                  req_d = 1'b1;
                  st_d = ST_SEND;
               end
            end
         end
         ST_BACKOFF: begin
            if (tmr_q == 16'h0000) begin
               tries_d = tries_q + 9'h001;
               req_d = 1'b1;
               st_d = ST_SEND;
            end
         end
         ST_POLL: begin
            if (RADIO_TX_DONE) begin
               // gap of the poll interval, ascending wrap
               ptmr_d = pint_q + 16'h0001;
               paddr_d = (paddr_q >= plast_q || paddr_q < pfirst_q) ? pfirst_q
                  : paddr_q + 16'h0001;
               st_d = ST_IDLE;
            end
         end
         default: st_d = ST_IDLE;
      endcase
      if (role_q != ROLE_POLL_BASE) begin
         paddr_d = pfirst_q;
      end
   end

   // Register sequencer and receive state
   always_ff @(posedge CLK) begin
      if (RST) begin
         st_q <= ST_IDLE;
         copies_q <= 8'h00;
         tries_q <= 9'h000;
         ackm_q <= 1'b0;
         seq_q <= 8'h00;
         tmr_q <= 16'h0000;
         ptmr_q <= 16'h0000;
         paddr_q <= `RRPC_RST_FIRST_POLLED;
         polled_q <= 1'b0;
         hold_q <= 20'h00000;
         hrun_q <= 1'b0;
         req_q <= 1'b0;
         tx_q <= '0;
         take_q <= 1'b0;
         acked_q <= 1'b0;
         ledtx_q <= 1'b0;
         ledrx_q <= 1'b0;
         ms_cnt_q <= '0;
         dup_ptr_q <= '0;
      end else begin
         st_q <= st_d;
         copies_q <= copies_d;
         tries_q <= tries_d;
         ackm_q <= ackm_d;
         seq_q <= seq_d;
         tmr_q <= tmr_d;
         ptmr_q <= ptmr_d;
         paddr_q <= paddr_d;
         polled_q <= polled_d;
         hold_q <= hold_d;
         hrun_q <= hrun_d;
         req_q <= req_d;
         tx_q <= tx_d;
         take_q <= take_d;
         acked_q <= acked_d;
         ledtx_q <= ledtx_d;
         ledrx_q <= ledrx_d;
         ms_cnt_q <= ms_cnt_d;
         dup_ptr_q <= dup_ptr_d;
      end
   end

   // Receive outcome strobes
   logic deliver_q, drop_q;
   always_ff @(posedge CLK) begin
      if (RST) begin
         deliver_q <= 1'b0;
         drop_q <= 1'b0;
      end else begin
         deliver_q <= deliver_d;
         drop_q <= drop_d;
      end
   end

   // ----------------------------------------
   // Outputs
   // ----------------------------------------
   assign RSP_VALID = rsp_valid_q;
   assign RSP_ERR = rsp_err_q;
   assign RSP_DATA = rsp_data_q;
   assign HOST_PKT_TAKE = take_q;
   assign HOST_PKT_ACKED = acked_q;
   assign RADIO_TX_REQ = req_q;
   assign RADIO_TX = tx_q;
   assign HOST_DELIVER = deliver_q;
   assign RX_DUP_DROP = drop_q;
   assign LED_TX = ledtx_q;
   assign LED_RX = ledrx_q;

endmodule // rrpc_ctrl

// ===== src/rrpc_lfsr.sv
// Purpose: Pseudo random source for the back-off delay
// Assumes: Free running on CLK
// Notes: 16-bit Galois shift register, never reaches zero
`timescale 1ns/10ps

module rrpc_lfsr #(
   parameter logic [15:0] SEED = 16'hACE1
) (
   input wire logic CLK,
   input wire logic RST,
   output logic [7:0] RAND
);

   logic [15:0] lfsr_q; // Shift register
   logic [15:0] lfsr_d; // Next value

   // Shift with feedback taps 16,14,13,11
   always_comb begin
      lfsr_d = {1'b0, lfsr_q[15:1]};
      if (lfsr_q[0]) begin
         lfsr_d = lfsr_d ^ 16'hB400;
      end
   end

   // Register the state
   always_ff @(posedge CLK) begin
      if (RST) begin
         lfsr_q <= SEED;
      end else begin
         lfsr_q <= lfsr_d;
      end
   end

   assign RAND = lfsr_q[7:0];

endmodule // rrpc_lfsr

// ===== src/rrpc_map.svh
// Purpose: Offsets, reset values and timing counts of the retry and polling controller
// Assumes: Included by the controller and the bench by bare name
// Notes: Definitions only
`ifndef RRPC_MAP_SVH
`define RRPC_MAP_SVH

// ----------------------------------------
// Command codes of the settings
// ----------------------------------------
`define RRPC_OFS_DEST_ADDR 8'h00
`define RRPC_OFS_ADDR_MASK 8'h12
`define RRPC_OFS_RETRY_LIMIT 8'h18
`define RRPC_OFS_RAND_SLOTS 8'h19
`define RRPC_OFS_MISSED_ACK 8'h1B
`define RRPC_OFS_OWN_ADDR 8'h2A
`define RRPC_OFS_RADIO_ROLE 8'h31
`define RRPC_OFS_REPEAT_COUNT 8'h3D
`define RRPC_OFS_POLL_INTERVAL 8'h40
`define RRPC_OFS_FIRST_POLLED 8'h41
`define RRPC_OFS_LAST_POLLED 8'h42

// ----------------------------------------
// Reset values
// ----------------------------------------
`define RRPC_RST_DEST_ADDR 16'h0000
`define RRPC_RST_ADDR_MASK 16'hFFFF
`define RRPC_RST_RETRY_LIMIT 8'h0A
`define RRPC_RST_RAND_SLOTS 8'h00
`define RRPC_RST_MISSED_ACK 16'h0000
`define RRPC_RST_OWN_ADDR 16'hFFFF
`define RRPC_RST_RADIO_ROLE 3'h0
`define RRPC_RST_REPEAT_COUNT 8'h00
`define RRPC_RST_POLL_INTERVAL 16'h0040
`define RRPC_RST_FIRST_POLLED 16'h0000
`define RRPC_RST_LAST_POLLED 16'h0003
`define RRPC_BCAST_ADDR 16'hFFFF

// ----------------------------------------
// Timing
// ----------------------------------------
`define RRPC_CLK_PERIOD_NS 100
`define RRPC_MS_NS 1000000
`define RRPC_MS_CYCLES (`RRPC_MS_NS / `RRPC_CLK_PERIOD_NS)
`define RRPC_REMOTE_HOLD_SCALE 20'h0000A
`define RRPC_ACK_WAIT_MS 16'h0014
`define RRPC_SLOT_MS 16'h0002

`endif

// ===== src/rrpc_pkg.sv
// Purpose: Types shared by the retry and polling controller
// Assumes: rrpc_map.svh holds the numbers
// Notes: Packet identifier and radio request travel as packed structs
package rrpc_pkg;

   // ----------------------------------------
   // Radio roles
   // ----------------------------------------
   typedef enum logic [2:0] {
      ROLE_NORMAL = 3'b000,
      ROLE_POLL_BASE = 3'b011,
      ROLE_POLL_REMOTE = 3'b100,
      ROLE_REPEATER = 3'b101,
      ROLE_REPEATER_END = 3'b110
   } rrpc_role_t;

   // ----------------------------------------
   // Transmit sequencer states
   // ----------------------------------------
   typedef enum logic [2:0] {
      ST_IDLE = 3'b000,
      ST_SEND = 3'b001,
      ST_ACK_WAIT = 3'b010,
      ST_BACKOFF = 3'b011,
      ST_POLL = 3'b100
   } rrpc_state_t;

   // Packet identifier: sender address and running number
   typedef struct packed {
      logic [15:0] src;
      logic [7:0] seq;
   } rrpc_id_t;

   // One radio transmission request
   typedef struct packed {
      logic init;
      logic poll;
      logic [15:0] dest;
      rrpc_id_t id;
   } rrpc_tx_t;

endpackage
